// ===== rtl/swl_pkg.sv
package swl_pkg;

  // ****************************************
  // Keys and widths
  // ****************************************
  localparam int DataWidth = 32;
  localparam int NumProt = 9;
  localparam logic [31:0] KeyFirst = 32'hAA99_6655;
  localparam logic [31:0] KeySecond = 32'h5566_99AA;
  localparam logic [31:0] StatLocked = 32'h0000_0000;
  localparam logic [31:0] StatUnlocked = 32'h0000_0001;
  localparam logic RstUnlocked = 1'b0;

  // ****************************************
  // Protected register select, one-hot index
  // ****************************************
  localparam int SelOscCtl = 0;
  localparam int SelPllCtl = 1;
  localparam int SelFrcTune = 2;
  localparam int SelModDis = 3;
  localparam int SelSwReset = 4;
  localparam int SelPinSel = 5;
  localparam int SelNmiCtl = 6;
  localparam int SelPwrCtl = 7;
  localparam int SelRtcCtl = 8;

  typedef enum {
    SWL_LOCKED,
    SWL_ARMED,
    SWL_OPEN
  } swl_state_t;

  typedef struct packed {
    logic wrEn;
    logic [NumProt-1:0] sel;
    logic [31:0] data;
  } swl_wr_t;

endpackage : swl_pkg

// ===== rtl/swl_write_lock.sv
`timescale 1ns/1ns
module swl_write_lock (
  input wire logic clk,
  input wire logic rst,
  input wire logic keyWrEn,
  input wire logic [31:0] keyWrData,
  input wire swl_pkg::swl_wr_t protReq,
  output swl_pkg::swl_wr_t protGrant,
  output logic [31:0] keyRdData,
  output logic unlocked
);
  import swl_pkg::*;

  // ****************************************
  // Key word decoding
  // ****************************************

  // Either key word; such a write never relocks an open gate
  function automatic logic isKeyWord(input logic [31:0] d);
    return (d == KeyFirst) || (d == KeySecond);
  endfunction : isKeyWord

  wire isFirst = keyWrData == KeyFirst;
  wire isSecond = keyWrData == KeySecond;
  wire keyStray = keyWrEn && !isKeyWord(keyWrData);

  // ****************************************
  // Sequence tracking
  // ****************************************

  swl_state_t state_r;
  swl_state_t state_nxt;
  wire lockedNow = state_r == SWL_LOCKED;
  wire armedNow = state_r == SWL_ARMED;
  wire openNow = state_r == SWL_OPEN;
  wire openNxt = state_nxt == SWL_OPEN;

  always_comb begin
    state_nxt = state_r;
    if (keyWrEn) begin
      unique case (state_r)
        SWL_LOCKED: begin
          // A lone second key is ignored
          state_nxt = isFirst ? SWL_ARMED : SWL_LOCKED;
        end
        SWL_ARMED: begin
          // A second key completes the unlock; a repeated first key stays armed, anything else abandons
          if (isSecond) begin
            state_nxt = SWL_OPEN;
          end else if (isFirst) begin
            state_nxt = SWL_ARMED;
          end else begin
            state_nxt = SWL_LOCKED;
          end
        end
        SWL_OPEN: begin
          // Key words keep it open; anything else relocks
          state_nxt = isKeyWord(keyWrData) ? SWL_OPEN : SWL_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= SWL_LOCKED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Write gate for the nine protected registers
  // ****************************************

  logic [NumProt-1:0] selGated;
  wire protHit = protReq.wrEn && (|protReq.sel);
  wire passWr = protHit && openNow;

  // One gate per protected register, oscillator control through rtc control one
  for (genvar g = 0; g < NumProt; g++) begin : g_slot
    assign selGated[g] = openNow && protReq.sel[g];
    a_slot_gated: assert property (@(posedge clk) disable iff (rst)
      protGrant.sel[g] |-> $past(openNow && protReq.sel[g]))
      else $error("protected slot passed while locked");
  end : g_slot

  // ****************************************
  // Registered outputs
  // ****************************************

  swl_wr_t grantNxt;
  wire [31:0] statusNxt = openNxt ? StatUnlocked : StatLocked;
  assign grantNxt = '{wrEn: passWr, sel: selGated, data: protReq.data};

  always_ff @(posedge clk) begin
    if (rst) begin
      protGrant <= '0;
      keyRdData <= StatLocked;
      unlocked <= RstUnlocked;
    end else begin
      protGrant <= grantNxt;
      keyRdData <= statusNxt;
      unlocked <= openNxt;
    end
  end

  // ****************************************
  // Key sequence shapes
  // ****************************************

  sequence firstWr;
    keyWrEn && isFirst;
  endsequence

  sequence secondWr;
    keyWrEn && isSecond;
  endsequence

  sequence keyPair;
    firstWr ##1 secondWr;
  endsequence

  sequence brokenPair;
    keyStray ##1 secondWr;
  endsequence

  sequence rearmPair;
    firstWr ##1 keyPair;
  endsequence

  // ****************************************
  // Unlock checks
  // ****************************************

  a_pair_unlocks: assert property (@(posedge clk) disable iff (rst)
    lockedNow ##0 keyPair |=> unlocked)
    else $error("key pair did not unlock");

  a_rearm_unlocks: assert property (@(posedge clk) disable iff (rst)
    rearmPair |=> unlocked)
    else $error("repeated first key then second key did not unlock");

  a_lone_second: assert property (@(posedge clk) disable iff (rst)
    lockedNow ##0 secondWr |=> !unlocked)
    else $error("second key alone unlocked");

  a_break_abandons: assert property (@(posedge clk) disable iff (rst)
    armedNow ##0 brokenPair |=> !unlocked)
    else $error("broken sequence unlocked");

  a_armed_shut: assert property (@(posedge clk) disable iff (rst)
    armedNow |-> !unlocked)
    else $error("gate open after first key only");

  a_open_needs_pair: assert property (@(posedge clk) disable iff (rst)
    $rose(unlocked) |-> $past(armedNow && keyWrEn && isSecond))
    else $error("gate opened without the key pair");

  // ****************************************
  // Relock and status checks
  // ****************************************

  a_nonkey_relocks: assert property (@(posedge clk) disable iff (rst)
    keyStray |=> !unlocked && keyRdData == StatLocked)
    else $error("non-key write did not relock");

  a_key_keeps_open: assert property (@(posedge clk) disable iff (rst)
    openNow && keyWrEn && isKeyWord(keyWrData) |=> unlocked)
    else $error("key word closed an open gate");

  a_close_needs_stray: assert property (@(posedge clk) disable iff (rst)
    $fell(unlocked) && !$past(rst) |-> $past(keyStray))
    else $error("gate closed without a non-key write");

  a_idle_holds: assert property (@(posedge clk) disable iff (rst)
    !keyWrEn |=> $stable(unlocked))
    else $error("lock state moved without a key write");

  a_status_read: assert property (@(posedge clk) disable iff (rst)
    keyRdData == (openNow ? StatUnlocked : StatLocked))
    else $error("status read mismatch");

  a_status_flag: assert property (@(posedge clk) disable iff (rst)
    unlocked == openNow)
    else $error("unlocked flag does not follow the gate");

  // ****************************************
  // Write gate checks
  // ****************************************

  a_blocked_when_locked: assert property (@(posedge clk) disable iff (rst)
    !openNow |=> !protGrant.wrEn)
    else $error("protected write passed while locked");

  a_locked_no_sel: assert property (@(posedge clk) disable iff (rst)
    !openNow |=> protGrant.sel == '0)
    else $error("protected select passed while locked");

  a_grant_idle: assert property (@(posedge clk) disable iff (rst)
    !protHit |=> !protGrant.wrEn)
    else $error("grant without a request");

  a_open_passes: assert property (@(posedge clk) disable iff (rst)
    openNow && protHit |=> protGrant.wrEn)
    else $error("unlocked write not passed");

  a_grant_selects: assert property (@(posedge clk) disable iff (rst)
    protGrant.wrEn |-> $past(protReq.sel) == protGrant.sel)
    else $error("grant select mismatch");

  a_grant_data: assert property (@(posedge clk) disable iff (rst)
    protGrant.wrEn |-> protGrant.data == $past(protReq.data))
    else $error("grant data mismatch");

endmodule : swl_write_lock

// ===== test/swl_write_lock_bench.sv
`timescale 1ns/1ns
module swl_write_lock_bench;
  import swl_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic keyWrEn = 0;
  logic [31:0] keyWrData = '0;
  swl_wr_t protReq = '0;
  swl_wr_t protGrant;
  logic [31:0] keyRdData;
  logic unlocked;
  int numErrors = 0;
  int checked = 0;
  int cycles = 0;
  swl_write_lock i_swl_write_lock (.clk(clk), .rst(rst), .keyWrEn(keyWrEn),
    .keyWrData(keyWrData), .protReq(protReq), .protGrant(protGrant),
    .keyRdData(keyRdData), .unlocked(unlocked));
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask : cmp
  task automatic print_verdict;
    $display("errors %0d checks %0d", numErrors, checked);
    if (numErrors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic keyWr(input logic [31:0] d);
    @(negedge clk);
    keyWrEn = 1;
    keyWrData = d;
    @(negedge clk);
    keyWrEn = 0;
  endtask : keyWr
  // Two or three key writes in adjacent cycles, as with interrupts held off
  task automatic keyRun(input int n, input logic [31:0] a, input logic [31:0] b,
      input logic [31:0] c);
    @(negedge clk);
    keyWrEn = 1;
    keyWrData = a;
    @(negedge clk);
    keyWrData = b;
    if (n == 3) begin
      @(negedge clk);
      keyWrData = c;
    end
    @(negedge clk);
    keyWrEn = 0;
  endtask : keyRun
  task automatic lockIs(input logic u);
    cmp("unlocked", {31'h0, u}, {31'h0, unlocked});
    cmp("keyRdData", u ? StatUnlocked : StatLocked, keyRdData);
  endtask : lockIs
  // Walks every protected select; a grant carries the select only when open
  task automatic protAll(input logic u);
    logic [31:0] expGrant;
    for (int i = 0; i < NumProt; i++) begin
      @(negedge clk);
      protReq = '{1'b1, 9'(1 << i), 32'h1234_5678};
      @(negedge clk);
      protReq = '0;
      expGrant = {22'h0, u, u ? 9'(1 << i) : 9'h0};
      cmp("grant", expGrant, {22'h0, protGrant.wrEn, protGrant.sel});
      cmp("grantData", 32'h1234_5678, protGrant.data);
    end
  endtask : protAll
  task automatic lockedScen;
    lockIs(0);
    protAll(0);
  endtask : lockedScen
  task automatic unlockScen;
    keyRun(2, KeyFirst, KeySecond, 32'h0000_0000);
    lockIs(1);
    protAll(1);
    keyWr(KeyFirst);
    keyWr(KeySecond);
    lockIs(1);
    keyWr(32'h0000_0000);
    lockIs(0);
    protAll(0);
    keyWr(KeyFirst);
    keyWr(KeySecond);
    lockIs(1);
    keyWr(32'h0000_0000);
    lockIs(0);
  endtask : unlockScen
  task automatic abandonScen;
    keyRun(3, KeyFirst, 32'h0000_1234, KeySecond);
    lockIs(0);
    keyWr(KeySecond);
    lockIs(0);
    keyRun(3, KeyFirst, KeyFirst, KeySecond);
    lockIs(1);
    keyWr(32'h0000_0000);
    lockIs(0);
  endtask : abandonScen
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      numErrors++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    lockedScen();
    unlockScen();
    abandonScen();
    print_verdict();
  end
endmodule : swl_write_lock_bench
